// ---- logic/icp_pkg.sv ----
// Shared constants and types for the interrupt acceptance controller and its CPU end.
package icp_pkg;
    // Source population: low indices are pins, high indices are on-chip events.
    localparam int N_SRC = 8;
    localparam int N_EXT = 4;
    localparam int LVL_W = 3;
    localparam int VEC_W = 8;
    localparam int ADDR_W = 16;
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;

    typedef logic [LVL_W-1:0] icp_lvl_t;
    typedef logic [VEC_W-1:0] icp_vec_t;

    // Interrupt control mode field values.
    typedef enum logic [1:0] {
        ICP_MODE0 = 2'b00,
        ICP_MODE2 = 2'b10
    } icp_mode_e;

    // Register byte offsets on the Wishbone slave.
    localparam logic [WB_AW-1:0] OFS_SYSCFG = 8'h00;
    localparam logic [WB_AW-1:0] OFS_ENABLE = 8'h04;
    localparam logic [WB_AW-1:0] OFS_PRIO = 8'h08;
    localparam logic [WB_AW-1:0] OFS_PEND = 8'h0C;
    localparam logic [WB_AW-1:0] OFS_STAT = 8'h10;

    // Reset values.
    localparam logic [N_SRC-1:0] ENABLE_RST = 8'h00;
    localparam logic [N_SRC*LVL_W-1:0] PRIO_RST = 24'hFFFFFF;
    localparam icp_lvl_t MASK_RST = 3'h7;
    localparam icp_lvl_t LVL_ZERO = 3'h0;
    localparam logic I_BIT_RST = 1'b1;

    // Levels and vectors.
    localparam icp_lvl_t NMI_LEVEL = 3'h7;
    localparam icp_vec_t VEC_NMI = 8'h07;
    localparam icp_vec_t VEC_BASE = 8'h10;
    localparam int VEC_ADDR_SHIFT = 2;

    // Timing in states, one state per clock.
    localparam logic [1:0] PRI_EXT_STATES = 2'h3;
    localparam logic [1:0] PRI_INT_STATES = 2'h2;
    localparam logic [1:0] MASK_HOLD_STATES = 2'h3;
    localparam logic [1:0] STACK_N_MODE0 = 2'h2;
    localparam logic [1:0] STACK_N_MODE2 = 2'h3;
    localparam logic [1:0] VEC_FETCH_N = 2'h2;
    localparam logic [1:0] INTPROC_N = 2'h2;
    localparam logic [1:0] PREFETCH_N = 2'h2;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_ZERO = 2'h0;
endpackage

// ---- logic/icp_if.sv ----
// Link between the interrupt controller and the CPU exception logic.
interface icp_if;
    import icp_pkg::*;
    logic mode2;
    logic irq_req;
    icp_vec_t irq_vec;
    icp_lvl_t irq_level;
    logic irq_nmi;
    logic irq_ack;
    logic cpu_i_bit;
    icp_lvl_t cpu_mask_level;
    logic cpu_mask_update;

    modport ctl (
        output mode2, irq_req, irq_vec, irq_level, irq_nmi,
        input irq_ack, cpu_i_bit, cpu_mask_level, cpu_mask_update
    );
    modport cpu (
        input mode2, irq_req, irq_vec, irq_level, irq_nmi,
        output irq_ack, cpu_i_bit, cpu_mask_level, cpu_mask_update
    );
endinterface

// ---- logic/icp_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter.
module icp_pin_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } icp_sync_s;

    icp_sync_s st_reg;
    icp_sync_s st_next;

    // The level only moves once the second and third stages agree, so a glitch is dropped.
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.lvl = st_reg.s3;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.lvl;
endmodule

// ---- logic/icp_ctrl.sv ----
// Interrupt acceptance controller with Wishbone registers and pin synchronisers.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
module icp_ctrl (
    input wire logic clk,
    input wire logic reset,
    icp_if.ctl link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [icp_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [icp_pkg::WB_DW-1:0] wb_dat_i,
    output logic [icp_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [icp_pkg::N_EXT-1:0] ext_irq_pin,
    input wire logic nmi_pin,
    input wire logic [icp_pkg::N_SRC-icp_pkg::N_EXT-1:0] int_event
);
    import icp_pkg::*;

    typedef struct packed {
        logic [1:0] mode;
        logic [N_SRC-1:0] enable;
        logic [N_SRC*LVL_W-1:0] prio;
        logic [N_SRC-1:0] pend;
        logic nmi_pend;
        logic [N_EXT-1:0] ext_prev;
        logic nmi_prev;
        logic win_valid;
        logic win_nmi;
        logic [2:0] win_idx;
        icp_lvl_t win_lvl;
        icp_vec_t win_vec;
        logic [1:0] det_cnt;
        logic [1:0] hold_cnt;
        icp_vec_t last_vec;
        logic wb_ack;
        logic [WB_DW-1:0] wb_dat;
    } icp_ctl_s;

    icp_ctl_s st_reg;
    icp_ctl_s st_next;

    logic [N_EXT:0] pin_lvl;
    logic [N_EXT:0] pin_raw;
    logic irq_req;
    logic [1:0] need;

    assign pin_raw = {nmi_pin, ext_irq_pin};

    // Every pin crosses in through its own synchroniser.
    genvar g;
    generate
        for (g = 0; g <= N_EXT; g++) begin : g_sync
            icp_pin_sync u_sync (
                .clk(clk),
                .reset(reset),
                .pin_in(pin_raw[g]),
                .level_out(pin_lvl[g])
            );
        end
    endgenerate

    // Pins pay one extra state of determination over on-chip sources.
    assign need = (st_reg.win_nmi || st_reg.win_idx < 3'(N_EXT)) ? PRI_EXT_STATES
                                                                 : PRI_INT_STATES;

    // The request is offered only once determination is done and the mask-load hold has lapsed.
    assign irq_req = st_reg.win_valid && (st_reg.det_cnt == need)
                     && (st_reg.hold_cnt == CNT_ZERO);

    // Next-state logic: sources, arbitration, determination and the register slave.
    always_comb begin
        logic [N_SRC-1:0] events;
        logic [N_SRC-1:0] clr;
        logic [N_SRC-1:0] lanes8;
        logic [WB_DW-1:0] wmask;
        logic nmi_rise;
        logic nmi_clr;
        logic found;
        logic [2:0] c_idx;
        icp_lvl_t c_lvl;
        icp_lvl_t lvl_i;
        logic eligible;
        logic w_valid;
        logic w_nmi;
        logic wr;
        st_next = st_reg;
        events = '0;
        lvl_i = LVL_ZERO;
        eligible = 1'b0;
        nmi_rise = 1'b0;
        w_valid = 1'b0;
        w_nmi = 1'b0;
        clr = '0;
        nmi_clr = 1'b0;
        found = 1'b0;
        c_idx = '0;
        c_lvl = LVL_ZERO;
        lanes8 = '0;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        // A write lands at the same edge at which the master sees ack high.
        wr = wb_cyc_i && wb_stb_i && wb_we_i && st_reg.wb_ack;

        // Pin sources request on a rising level; on-chip sources pulse.
        st_next.ext_prev = pin_lvl[N_EXT-1:0];
        st_next.nmi_prev = pin_lvl[N_EXT];
        events = {int_event, pin_lvl[N_EXT-1:0] & ~st_reg.ext_prev};
        nmi_rise = pin_lvl[N_EXT] && !st_reg.nmi_prev;

        // Pick the highest level; scanning downward with >= lets the lower index win ties.
        for (int i = N_SRC - 1; i >= 0; i--) begin
            lvl_i = (st_reg.mode == ICP_MODE2) ? st_reg.prio[i*LVL_W +: LVL_W]
                                               : LVL_ZERO;
            if (st_reg.pend[i] && (!found || lvl_i >= c_lvl)) begin
                found = 1'b1;
                c_idx = 3'(i);
                c_lvl = lvl_i;
            end
        end
        if (st_reg.mode == ICP_MODE2) begin
            eligible = c_lvl > link.cpu_mask_level;
        end else begin
            eligible = !link.cpu_i_bit;
        end
        w_nmi = st_reg.nmi_pend;
        w_valid = w_nmi || (found && eligible);

        // Any change of winner restarts determination.
        if (w_valid != st_reg.win_valid || w_nmi != st_reg.win_nmi
            || (!w_nmi && c_idx != st_reg.win_idx)) begin
            st_next.det_cnt = CNT_ZERO;
        end else if (st_reg.det_cnt != need) begin
            st_next.det_cnt = st_reg.det_cnt + CNT_ONE;
        end
        st_next.win_valid = w_valid;
        st_next.win_nmi = w_nmi;
        st_next.win_idx = w_nmi ? '0 : c_idx;
        st_next.win_lvl = w_nmi ? NMI_LEVEL : c_lvl;
        st_next.win_vec = w_nmi ? VEC_NMI : VEC_BASE + icp_vec_t'(c_idx);

        // A mask load by the CPU blocks acceptance for a fixed number of states.
        if (link.cpu_mask_update) begin
            st_next.hold_cnt = MASK_HOLD_STATES;
        end else if (st_reg.hold_cnt != CNT_ZERO) begin
            st_next.hold_cnt = st_reg.hold_cnt - CNT_ONE;
        end

        // Acceptance retires the winner's pending flag.
        if (irq_req && link.irq_ack) begin
            if (st_reg.win_nmi) begin
                nmi_clr = 1'b1;
            end else begin
                clr[st_reg.win_idx] = 1'b1;
            end
            st_next.last_vec = st_reg.win_vec;
            st_next.det_cnt = CNT_ZERO;
            st_next.win_valid = 1'b0;
        end

        // Software write-one-to-clear of pending flags through lane 0 and lane 1.
        if (wr && wb_adr_i == OFS_PEND) begin
            lanes8 = wb_sel_i[0] ? wb_dat_i[N_SRC-1:0] : '0;
            clr = clr | lanes8;
            nmi_clr = nmi_clr || (wb_sel_i[1] && wb_dat_i[N_SRC]);
        end

        // A new event beats a clear in the same cycle.
        st_next.pend = (st_reg.pend & ~clr) | (events & st_reg.enable);
        st_next.nmi_pend = (st_reg.nmi_pend && !nmi_clr) || nmi_rise;

        // Writes honour byte lanes; a mode write other than 0 or 2 is dropped.
        if (wr) begin
            case (wb_adr_i)
                OFS_SYSCFG: begin
                    if (wb_sel_i[0] && (wb_dat_i[1:0] == ICP_MODE0
                                        || wb_dat_i[1:0] == ICP_MODE2)) begin
                        st_next.mode = wb_dat_i[1:0];
                    end
                end
                OFS_ENABLE: begin
                    st_next.enable = (st_reg.enable & ~wmask[N_SRC-1:0])
                                     | (wb_dat_i[N_SRC-1:0] & wmask[N_SRC-1:0]);
                end
                OFS_PRIO: begin
                    st_next.prio = (st_reg.prio & ~wmask[N_SRC*LVL_W-1:0])
                                   | (wb_dat_i[N_SRC*LVL_W-1:0] & wmask[N_SRC*LVL_W-1:0]);
                end
                default: begin
                    // Pending clears are handled above; status and holes ignore writes.
                end
            endcase
        end

        // Classic single-cycle answer: ack one cycle after the strobe, dropped the next.
        st_next.wb_ack = wb_cyc_i && wb_stb_i && !st_reg.wb_ack;
        case (wb_adr_i)
            OFS_SYSCFG: st_next.wb_dat = WB_DW'(st_reg.mode);
            OFS_ENABLE: st_next.wb_dat = WB_DW'(st_reg.enable);
            OFS_PRIO: st_next.wb_dat = WB_DW'(st_reg.prio);
            OFS_PEND: st_next.wb_dat = WB_DW'({st_reg.nmi_pend, st_reg.pend});
            OFS_STAT: begin
                st_next.wb_dat = WB_DW'({irq_req, st_reg.hold_cnt != CNT_ZERO,
                                         st_reg.last_vec});
            end
            default: st_next.wb_dat = '0;
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.enable <= ENABLE_RST;
            st_reg.prio <= PRIO_RST;
            st_reg.mode <= ICP_MODE0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Link and bus outputs.
    assign link.mode2 = (st_reg.mode == ICP_MODE2);
    assign link.irq_req = irq_req;
    assign link.irq_vec = st_reg.win_vec;
    assign link.irq_level = st_reg.win_lvl;
    assign link.irq_nmi = st_reg.win_nmi;
    assign wb_ack_o = st_reg.wb_ack;
    assign wb_dat_o = st_reg.wb_dat;
endmodule

// ---- logic/icp_cpu_end.sv ----
// CPU side of the link: mask state, acceptance and the exception sequence.
module icp_cpu_end (
    input wire logic clk,
    input wire logic reset,
    icp_if.cpu link,
    input wire logic instr_done,
    input wire logic ldc_we,
    input wire logic ldc_i_bit,
    input wire logic [icp_pkg::LVL_W-1:0] ldc_mask,
    input wire logic ldc_trace,
    output logic exc_busy,
    output logic stack_push,
    output logic vec_fetch,
    output logic [icp_pkg::ADDR_W-1:0] vec_addr,
    output logic handler_start,
    output logic i_bit,
    output logic [icp_pkg::LVL_W-1:0] mask_level,
    output logic trace_bit
);
    import icp_pkg::*;

    typedef enum logic [2:0] {
        CPU_IDLE = 3'b000,
        CPU_STACK = 3'b001,
        CPU_VEC = 3'b010,
        CPU_INTP = 3'b011,
        CPU_PREF = 3'b100
    } icp_cpu_e;

    typedef struct packed {
        icp_cpu_e state;
        logic [1:0] cnt;
        logic mode2;
        icp_vec_t vec;
        icp_lvl_t lvl;
        logic i_bit;
        icp_lvl_t mask;
        logic trace;
        logic [ADDR_W-1:0] vec_addr;
        logic stack_push;
        logic vec_fetch;
        logic handler_start;
        logic mask_update;
    } icp_cpu_s;

    icp_cpu_s st_reg;
    icp_cpu_s st_next;
    logic ack;

    // Acceptance only at an instruction boundary while idle.
    assign ack = (st_reg.state == CPU_IDLE) && link.irq_req && instr_done;

    // Exception sequence: one state per on-chip access.
    always_comb begin
        st_next = st_reg;
        st_next.stack_push = 1'b0;
        st_next.vec_fetch = 1'b0;
        st_next.handler_start = 1'b0;
        st_next.mask_update = 1'b0;
        case (st_reg.state)
            CPU_IDLE: begin
                if (ack) begin
                    st_next.state = CPU_STACK;
                    st_next.cnt = CNT_ZERO;
                    st_next.mode2 = link.mode2;
                    st_next.vec = link.irq_vec;
                    st_next.lvl = link.irq_nmi ? NMI_LEVEL : link.irq_level;
                end else if (ldc_we) begin
                    st_next.i_bit = ldc_i_bit;
                    st_next.mask = ldc_mask;
                    st_next.trace = ldc_trace;
                    st_next.mask_update = 1'b1;
                end
            end
            CPU_STACK: begin
                st_next.stack_push = 1'b1;
                st_next.cnt = st_reg.cnt + CNT_ONE;
                if (st_reg.cnt == (st_reg.mode2 ? STACK_N_MODE2 : STACK_N_MODE0) - CNT_ONE) begin
                    // Masks change at the last stack push, in the same cycle that push is signalled.
                    if (st_reg.mode2) begin
                        st_next.trace = 1'b0;
                        st_next.mask = st_reg.lvl;
                    end else begin
                        st_next.i_bit = 1'b1;
                    end
                    st_next.state = CPU_VEC;
                    st_next.cnt = CNT_ZERO;
                end
            end
            CPU_VEC: begin
                st_next.vec_fetch = 1'b1;
                st_next.vec_addr = ADDR_W'(st_reg.vec) << VEC_ADDR_SHIFT;
                st_next.cnt = st_reg.cnt + CNT_ONE;
                if (st_reg.cnt == VEC_FETCH_N - CNT_ONE) begin
                    st_next.state = CPU_INTP;
                    st_next.cnt = CNT_ZERO;
                end
            end
            CPU_INTP: begin
                st_next.cnt = st_reg.cnt + CNT_ONE;
                if (st_reg.cnt == INTPROC_N - CNT_ONE) begin
                    st_next.state = CPU_PREF;
                    st_next.cnt = CNT_ZERO;
                end
            end
            CPU_PREF: begin
                st_next.cnt = st_reg.cnt + CNT_ONE;
                if (st_reg.cnt == PREFETCH_N - CNT_ONE) begin
                    st_next.state = CPU_IDLE;
                    st_next.cnt = CNT_ZERO;
                    st_next.handler_start = 1'b1;
                end
            end
            default: begin
                st_next.state = CPU_IDLE;
            end
        endcase
    end

    // State register; masks come up closed so nothing maskable is taken before setup.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.state <= CPU_IDLE;
            st_reg.i_bit <= I_BIT_RST;
            st_reg.mask <= MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.irq_ack = ack;
    assign link.cpu_i_bit = st_reg.i_bit;
    assign link.cpu_mask_level = st_reg.mask;
    assign link.cpu_mask_update = st_reg.mask_update;
    assign exc_busy = (st_reg.state != CPU_IDLE);
    assign stack_push = st_reg.stack_push;
    assign vec_fetch = st_reg.vec_fetch;
    assign vec_addr = st_reg.vec_addr;
    assign handler_start = st_reg.handler_start;
    assign i_bit = st_reg.i_bit;
    assign mask_level = st_reg.mask;
    assign trace_bit = st_reg.trace;
endmodule

// ---- tb/icp_monitor.sv ----
// Concurrent checks on the link between the interrupt controller and the CPU end.
module icp_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic mode2,
    input wire logic irq_req,
    input wire icp_pkg::icp_vec_t irq_vec,
    input wire icp_pkg::icp_lvl_t irq_level,
    input wire logic irq_nmi,
    input wire logic irq_ack,
    input wire logic cpu_i_bit,
    input wire icp_pkg::icp_lvl_t cpu_mask_level,
    input wire logic cpu_mask_update
);
    import icp_pkg::*;
    icp_lvl_t lvl_seen_reg;

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Remember the level of the request taken last, for the mask reload check.
    always_ff @(posedge clk) begin
        if (irq_ack) begin
            lvl_seen_reg <= irq_level;
        end
    end

    // The CPU may only take a request that the controller is offering.
    ack_needs_req_a: assert property (irq_ack |-> irq_req)
        else $error("acknowledge without a request");
    // A taken request is withdrawn on the very next cycle.
    take_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
        else $error("request still offered after acceptance");
    // The mask bit is compared against its settled value, hence the past guard.
    mode0_mask_a: assert property (!mode2 && cpu_i_bit && $past(cpu_i_bit) && irq_req
        |-> irq_nmi)
        else $error("maskable request offered while the mask bit is set");
    mode2_level_a: assert property (mode2 && irq_req && !irq_nmi
        && $stable(cpu_mask_level) |-> irq_level > cpu_mask_level)
        else $error("request offered at or below the mask level");
    nmi_level_a: assert property (irq_req && irq_nmi
        |-> irq_level == NMI_LEVEL && irq_vec == VEC_NMI)
        else $error("non-maskable request with wrong level or vector");
    vec_range_a: assert property (irq_req && !irq_nmi
        |-> irq_vec >= VEC_BASE && irq_vec < VEC_BASE + 8'h08)
        else $error("maskable request with a vector outside the source range");
    mask_hold_a: assert property (cpu_mask_update |=> !irq_req [*3])
        else $error("request offered inside the hold after a mask load");
    i_bit_set_a: assert property (irq_ack && !mode2 |-> ##[1:12] cpu_i_bit)
        else $error("mask bit not set after acceptance in mode 0");
    lvl_load_a: assert property (irq_ack && mode2
        |-> ##[1:12] (cpu_mask_level == lvl_seen_reg))
        else $error("mask level not loaded with the accepted level");
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench joining the controller and the CPU end over the link.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import icp_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [WB_AW-1:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [WB_DW-1:0] wb_wdat = 32'h0;
    logic [WB_DW-1:0] wb_rdat;
    logic wb_ack;
    logic [N_EXT-1:0] ext_pin = 4'h0;
    logic nmi_pin = 1'b0;
    logic [N_SRC-N_EXT-1:0] int_event = 4'h0;
    logic instr_done = 1'b0;
    logic ldc_we = 1'b0;
    logic ldc_i_bit = 1'b0;
    logic [LVL_W-1:0] ldc_mask = 3'h0;
    logic ldc_trace = 1'b0;
    logic exc_busy, stack_push, vec_fetch, handler_start, i_bit, trace_bit;
    logic [ADDR_W-1:0] vec_addr;
    logic [LVL_W-1:0] mask_level;
    logic [31:0] rd;
    logic [15:0] va;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int pushes;
    int busy;
    int n;

    icp_if link ();
    icp_ctrl icp_ctrl_inst (.clk(clk), .reset(reset), .link(link), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ext_irq_pin(ext_pin),
        .nmi_pin(nmi_pin), .int_event(int_event));
    icp_cpu_end icp_cpu_end_inst (.clk(clk), .reset(reset), .link(link),
        .instr_done(instr_done), .ldc_we(ldc_we), .ldc_i_bit(ldc_i_bit), .ldc_mask(ldc_mask),
        .ldc_trace(ldc_trace), .exc_busy(exc_busy), .stack_push(stack_push),
        .vec_fetch(vec_fetch), .vec_addr(vec_addr), .handler_start(handler_start),
        .i_bit(i_bit), .mask_level(mask_level), .trace_bit(trace_bit));
    icp_monitor icp_monitor_inst (.clk(clk), .reset(reset), .mode2(link.mode2),
        .irq_req(link.irq_req), .irq_vec(link.irq_vec), .irq_level(link.irq_level),
        .irq_nmi(link.irq_nmi), .irq_ack(link.irq_ack), .cpu_i_bit(link.cpu_i_bit),
        .cpu_mask_level(link.cpu_mask_level), .cpu_mask_update(link.cpu_mask_update));

    // The clock toggles every half period of 4 ns.
    always #4 clk = ~clk;

    // Cut a hang short; the whole sequence needs well under two thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; the request stands until ack is sampled high.
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] wd);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= adr;
        wb_wdat <= wd;
        @(posedge clk);
        while (wb_ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        wb(adr, 1'b1, wd);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(adr, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    // A load leaves four idle cycles so the three-state hold has run out.
    task automatic ldc(input logic ib, input logic [2:0] m, input logic tr);
        ldc_we <= 1'b1;
        ldc_i_bit <= ib;
        ldc_mask <= m;
        ldc_trace <= tr;
        @(posedge clk);
        ldc_we <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic pulse(input logic [3:0] v);
        int_event <= v;
        @(posedge clk);
        int_event <= 4'h0;
    endtask

    // Let the CPU reach instruction ends until the handler starts, counting stack pushes.
    task automatic run_exc();
        pushes = 0;
        busy = 0;
        va = 16'h0;
        instr_done <= 1'b1;
        while (handler_start !== 1'b1) begin
            @(posedge clk);
            if (stack_push === 1'b1) pushes++;
            if (exc_busy === 1'b1) busy++;
            if (vec_fetch === 1'b1) va = vec_addr;
        end
        instr_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence; source 4 is int_event bit 0, source 0 is pin bit 0.
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdc(OFS_SYSCFG, 32'h0);
        rdc(OFS_ENABLE, 32'h0);
        rdc(OFS_PRIO, 32'h00FFFFFF);
        rdc(8'h14, 32'h0);
        wr(OFS_SYSCFG, 32'h1);
        rdc(OFS_SYSCFG, 32'h0);
        check(32'(i_bit), 32'h1);
        check(32'(mask_level), 32'h7);
        pulse(4'h1);
        repeat (8) @(posedge clk);
        rdc(OFS_PEND, 32'h0);
        $display("test reset_and_enable done");
        wr(OFS_ENABLE, 32'hFF);
        pulse(4'h1);
        repeat (8) @(posedge clk);
        check(32'(link.irq_req), 32'h0);
        rdc(OFS_PEND, 32'h10);
        nmi_pin <= 1'b1;
        run_exc();
        check(pushes, 32'h2);
        check(busy, 32'h8);
        check(32'(va), 32'h1C);
        rdc(OFS_STAT, 32'h7);
        rdc(OFS_PEND, 32'h10);
        ldc(1'b0, 3'h7, 1'b0);
        run_exc();
        check(pushes, 32'h2);
        check(32'(va), 32'h50);
        check(32'(i_bit), 32'h1);
        rdc(OFS_PEND, 32'h0);
        $display("test mode0 done");
        ldc(1'b0, 3'h7, 1'b0);
        pulse(4'h4);
        n = 1;
        while (link.irq_req !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check(n, 32'h5);
        repeat (3) @(posedge clk);
        check(32'(link.irq_req), 32'h1);
        check(32'(exc_busy), 32'h0);
        run_exc();
        check(32'(va), 32'h58);
        $display("test determination done");
        wr(OFS_SYSCFG, 32'h2);
        wr(OFS_SYSCFG, 32'h3);
        rdc(OFS_SYSCFG, 32'h2);
        wr(OFS_PRIO, 32'h0002D000);
        ldc(1'b0, 3'h4, 1'b1);
        pulse(4'h3);
        run_exc();
        check(pushes, 32'h3);
        check(busy, 32'h9);
        check(32'(va), 32'h50);
        check(32'(mask_level), 32'h5);
        check(32'(trace_bit), 32'h0);
        repeat (10) @(posedge clk);
        check(32'(link.irq_req), 32'h0);
        rdc(OFS_PEND, 32'h20);
        ldc(1'b0, 3'h4, 1'b0);
        run_exc();
        check(32'(va), 32'h54);
        nmi_pin <= 1'b0;
        repeat (6) @(posedge clk);
        nmi_pin <= 1'b1;
        run_exc();
        check(32'(va), 32'h1C);
        check(32'(mask_level), 32'h7);
        wr(OFS_PRIO, 32'h0002D006);
        ldc(1'b0, 3'h0, 1'b0);
        ext_pin <= 4'h1;
        run_exc();
        check(32'(va), 32'h40);
        check(32'(mask_level), 32'h6);
        $display("test mode2 done");
        report_and_stop();
    end
endmodule
